// >>> common/asps_pkg.sv
/*
 * Constants for the auxiliary scan point scanner: scan count limits,
 * report word layout, column decode, ring word and register map.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package asps_pkg;

	localparam int CNT_W = 11;
	localparam int RING_W = 16;
	localparam int COLS = 17;
	localparam int LL_DEPTH = 272;
	localparam int LL_AW = 9;
	localparam int REP_W = 32;

	// Scan count walk across the auxiliary points
	localparam logic [10:0] PT_FIRST = 11'h100;
	localparam logic [10:0] PT_GAP_FROM = 11'h148;
	localparam logic [10:0] PT_GAP_TO = 11'h400;
	localparam logic [10:0] PT_JUMP_FROM = 11'h480;
	localparam logic [10:0] PT_JUMP_TO = 11'h500;
	localparam logic [10:0] PT_LAST = 11'h53F;

	// Counter select line positions and group lines
	localparam int SEL_HI_BIT = 10;
	localparam int SEL_MID_BIT = 8;
	localparam int GRP_HI = 6;
	localparam int GRP_LO = 4;
	localparam logic [1:0] SEL_FIRST = 2'h1;
	localparam logic [1:0] SEL_SECOND = 2'h2;
	localparam logic [1:0] SEL_THIRD = 2'h3;
	localparam logic [4:0] COL_BASE_SECOND = 5'h05;
	localparam logic [4:0] COL_BASE_THIRD = 5'h0D;

	localparam logic [15:0] RING_INIT = 16'h0001;
	localparam logic [3:0] ROW_FIRST = 4'h0;
	localparam int ROW_UPPER_BIT = 3;

	// Direction category per column, one-way when set
	localparam logic [16:0] OW_ALL_DEF = 17'h1DDCE;
	localparam logic [16:0] OW_UPPER_DEF = 17'h02221;

	// Report word fields
	localparam int REP_MARKER_BIT = 28;
	localparam int REP_CNT_HI = 27;
	localparam int REP_CNT_LO = 17;
	localparam int REP_PSM_BIT = 16;

	localparam logic [1:0] RESCAN_FULL = 2'h3;
	localparam logic [1:0] RESCAN_IDLE = 2'h0;

	// Register map
	localparam int AW = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_REPORT = 4'h8;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int ST_SEND_BIT = 0;
	localparam int ST_HALT_BIT = 1;
	localparam int ST_UPD_BIT = 2;
	localparam int ST_PS_BIT = 3;
	localparam int ST_LL_BIT = 4;
	localparam int ST_OW_BIT = 5;
	localparam int ST_CNT_LO = 16;
	localparam int ST_CNT_HI = 26;

	typedef enum logic [3:0] {
		SL_ZERO = 4'b0001,
		SL_ONE = 4'b0010,
		SL_THIRTY_TWO = 4'b0100,
		SL_ADVANCE = 4'b1000
	} asps_slot_e;

endpackage

// >>> verilog/asps_scanner.sv
/*
 * Auxiliary scan point scanner: ring counter interrogation, column
 * select, present-state / last-look compare, report word assembly and
 * hand-off to the outgoing message control.
 * Assumes point circuits answer combinationally in the read slot and
 * that the message control pulses report_done_reset_i after sending.
 */
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/100ps

module asps_scanner #(
	parameter logic [16:0] OW_ALL = asps_pkg::OW_ALL_DEF,
	parameter logic [16:0] OW_UPPER = asps_pkg::OW_UPPER_DEF
) (
	input  wire logic                     ref_clk_i,
	input  wire logic                     reset_n_i,
	input  wire logic [asps_pkg::AW-1:0]  addr_i,
	input  wire logic [31:0]              wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	output logic      [31:0]              rdata_o,
	input  wire logic [asps_pkg::COLS-1:0] aux_point_out_i,
	input  wire logic                     report_done_reset_i,
	output logic                          ring_word_read_o,
	output logic                          ring_word_clear_o,
	output logic                          sixteenth_strobe_o,
	output logic [asps_pkg::RING_W-1:0]   ring_bits_o,
	output logic                          counter_select_hi_o,
	output logic                          counter_select_mid_o,
	output logic                          report_word_clear_o,
	output logic [asps_pkg::REP_W-1:0]    report_word_o,
	output logic                          state_bus_true_o,
	output logic                          state_bus_false_o,
	output logic                          send_report_strobe_o,
	output logic                          send_request_o,
	output logic [asps_pkg::CNT_W-1:0]    scan_count_o
);
	import asps_pkg::*;

	asps_slot_e             slot_reg;
	asps_slot_e             slot_next;
	logic [CNT_W-1:0]       count_reg;
	logic [CNT_W-1:0]       count_next;
	logic [RING_W-1:0]      ring_reg;
	logic [1:0]             rescan_reg;
	logic                   ps_reg;
	logic                   ll_reg;
	logic                   ow_reg;
	logic                   update_reg;
	logic                   halt_reg;
	logic                   send_reg;
	logic                   strobe_reg;
	logic                   enable_reg;
	logic [REP_W-1:0]       report_reg;
	logic                   bus_true_reg;
	logic                   bus_false_reg;
	logic [31:0]            rdata_reg;
	logic                   ll_store [LL_DEPTH];
	logic [LL_DEPTH-1:0]    ll_seen;

	logic                   scanning;
	logic                   upd_active;
	logic                   sixteenth;
	logic [1:0]             sel;
	logic [4:0]             col;
	logic                   col_valid;
	logic                   aux_common_bus;
	logic [LL_AW-1:0]       ll_idx;
	logic                   ow_now;
	logic                   advance;
	logic                   reportable;

	// Scanning only when no update or report is in progress
	assign scanning = enable_reg && !update_reg && !send_reg;
	assign upd_active = update_reg && !send_reg;
	assign sixteenth = (count_reg[3:0] == ROW_FIRST);

	// Column decode from the select and group lines
	assign sel = {count_reg[SEL_HI_BIT], count_reg[SEL_MID_BIT]};
	always_comb begin
		col = 5'h00;
		col_valid = 1'b0;
		case (sel)
			SEL_FIRST: begin
				col = {2'b00, count_reg[GRP_HI:GRP_LO]};
				col_valid = (count_reg < PT_GAP_FROM);
			end
			SEL_SECOND: begin
				col = COL_BASE_SECOND + {2'b00, count_reg[GRP_HI:GRP_LO]};
				col_valid = 1'b1;
			end
			SEL_THIRD: begin
				col = COL_BASE_THIRD + {3'b000, count_reg[GRP_LO+1:GRP_LO]};
				col_valid = 1'b1;
			end
			default: begin
				col = 5'h00;
				col_valid = 1'b0;
			end
		endcase
	end

	// Only the selected column reaches the common bus
	assign aux_common_bus = col_valid && aux_point_out_i[col];
	assign ll_idx = LL_AW'({col, count_reg[3:0]});

	// Direction category: whole column, or its upper eight rows
	assign ow_now = OW_ALL[col] ||
		(OW_UPPER[col] && count_reg[ROW_UPPER_BIT]);

	// One-way points report only a change to off-hook
	assign reportable = !ow_reg || ps_reg;

	// Count walk with gap and jump between column groups
	always_comb begin
		count_next = count_reg + 11'h001;
		if (count_reg == (PT_GAP_FROM - 11'h001))
			count_next = PT_GAP_TO;
		else if (count_reg == (PT_JUMP_FROM - 11'h001))
			count_next = PT_JUMP_TO;
		else if (count_reg == PT_LAST)
			count_next = PT_FIRST;
	end

	// Advance after a match, or after a finished update once no report is pending
	assign advance = (slot_reg == SL_ADVANCE) && enable_reg && !send_reg &&
		(update_reg || (rescan_reg == RESCAN_IDLE));

	// Slot sequencer; held in advance once halted while a report is out
	always_comb begin
		slot_next = slot_reg;
		case (slot_reg)
			SL_ZERO: slot_next = SL_ONE;
			SL_ONE: slot_next = SL_THIRTY_TWO;
			SL_THIRTY_TWO: slot_next = SL_ADVANCE;
			SL_ADVANCE: begin
				// Hold only once halted, so the update slots still build the report
				if (!(send_reg && halt_reg))
					slot_next = SL_ZERO;
			end
			default: slot_next = SL_ZERO;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			slot_reg <= SL_ZERO;
		else
			slot_reg <= slot_next;
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_reg <= PT_FIRST;
		end else if (advance) begin
			count_reg <= count_next;
		end
	end

	// Ring reloads on a sixteen-point boundary, otherwise rotates
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ring_reg <= RING_INIT;
		end else if (advance) begin
			if (count_next[3:0] == ROW_FIRST)
				ring_reg <= RING_INIT;
			else
				ring_reg <= {ring_reg[RING_W-2:0], ring_reg[RING_W-1]};
		end
	end

	// Present state and last look around the compare
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ps_reg <= 1'b0;
			ll_reg <= 1'b0;
			ow_reg <= 1'b0;
		end else if (scanning) begin
			case (slot_reg)
				SL_ZERO: begin
					ps_reg <= aux_common_bus;
					ll_reg <= 1'b0;
					ow_reg <= ow_now;
				end
				SL_ONE: ll_reg <= ll_seen[ll_idx] && ll_store[ll_idx];
				default: ll_reg <= ll_reg;
			endcase
		end
	end

	// Mismatch goes straight to the full rescan count
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rescan_reg <= RESCAN_IDLE;
		end else if (scanning && slot_reg == SL_THIRTY_TWO && ps_reg != ll_reg) begin
			rescan_reg <= RESCAN_FULL;
		end else if (advance) begin
			rescan_reg <= RESCAN_IDLE;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			update_reg <= 1'b0;
		end else if (advance) begin
			update_reg <= 1'b0;
		end else if (rescan_reg == RESCAN_FULL && slot_reg == SL_ADVANCE) begin
			update_reg <= 1'b1;
		end
	end

	// Request raised with a reportable mismatch; the done pulse clears it, set wins
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			send_reg <= 1'b0;
			strobe_reg <= 1'b0;
		end else begin
			strobe_reg <= 1'b0;
			if (scanning && slot_reg == SL_THIRTY_TWO && ps_reg != ll_reg &&
				reportable) begin
				send_reg <= 1'b1;
				strobe_reg <= 1'b1;
			end else if (report_done_reset_i) begin
				send_reg <= 1'b0;
			end
		end
	end

	// Halt set once a report is pending at update slot_one
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			halt_reg <= 1'b0;
		end else if (advance) begin
			halt_reg <= 1'b0;
		end else if (update_reg && send_reg && slot_reg == SL_ONE) begin
			halt_reg <= 1'b1;
		end
	end

	// Report word assembly in update slot_zero, suppressed by halt
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			report_reg <= '0;
		end else if (update_reg && !halt_reg && slot_reg == SL_ZERO) begin
			report_reg <= '0;
			report_reg[REP_MARKER_BIT] <= 1'b1;
			report_reg[REP_CNT_HI:REP_CNT_LO] <= count_reg;
			report_reg[REP_PSM_BIT] <= ps_reg;
		end
	end

	// Last look rewritten even when no report is sent
	always_ff @(posedge ref_clk_i) begin
		if (update_reg && slot_reg == SL_ONE)
			ll_store[ll_idx] <= ps_reg;
	end

	// Store has no reset; a point never written reads as on-hook
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			ll_seen <= '0;
		else if (update_reg && slot_reg == SL_ONE)
			ll_seen[ll_idx] <= 1'b1;
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus_true_reg <= 1'b0;
			bus_false_reg <= 1'b0;
		end else begin
			bus_true_reg <= update_reg && slot_reg == SL_ONE && ps_reg;
			bus_false_reg <= update_reg && slot_reg == SL_ONE && !ps_reg;
		end
	end

	// Register port: control write, status and report read
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			enable_reg <= CTRL_EN_RST;
		else if (wr_i && addr_i == REG_CTRL)
			enable_reg <= wdata_i[CTRL_EN_BIT];
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_reg <= '0;
		end else if (rd_i) begin
			rdata_reg <= '0;
			case (addr_i)
				REG_CTRL: rdata_reg[CTRL_EN_BIT] <= enable_reg;
				REG_STATUS: begin
					rdata_reg[ST_SEND_BIT] <= send_reg;
					rdata_reg[ST_HALT_BIT] <= halt_reg;
					rdata_reg[ST_UPD_BIT] <= update_reg;
					rdata_reg[ST_PS_BIT] <= ps_reg;
					rdata_reg[ST_LL_BIT] <= ll_reg;
					rdata_reg[ST_OW_BIT] <= ow_reg;
					rdata_reg[ST_CNT_HI:ST_CNT_LO] <= count_reg;
				end
				REG_REPORT: rdata_reg <= report_reg;
				default: rdata_reg <= '0;
			endcase
		end
	end

	// Read and clear strobes follow the slot directly; data and the send strobe come from flops
	assign ring_word_read_o = scanning && slot_reg == SL_ZERO;
	assign sixteenth_strobe_o = ring_word_read_o && sixteenth;
	assign ring_word_clear_o = sixteenth_strobe_o;
	assign ring_bits_o = ring_word_read_o ? ring_reg : '0;
	assign counter_select_hi_o = sel[1];
	assign counter_select_mid_o = sel[0];
	assign report_word_clear_o = upd_active && !halt_reg && slot_reg == SL_ZERO;
	assign report_word_o = report_reg;
	assign state_bus_true_o = bus_true_reg;
	assign state_bus_false_o = bus_false_reg;
	assign send_report_strobe_o = strobe_reg;
	assign send_request_o = send_reg;
	assign scan_count_o = count_reg;
	assign rdata_o = rdata_reg;

endmodule

// >>> testbench/asps_point_model.sv
/*
 * Behavioural model of the seventeen scan point gate circuits.
 * Assumes the testbench sets the off-hook state of each column.
 */
`timescale 1ns/100ps

module asps_point_model (
	input  wire logic        ref_clk_i,
	input  wire logic        ring_word_read_i,
	input  wire logic [15:0] ring_bits_i,
	input  wire logic [16:0] off_hook_i,
	output logic      [16:0] aux_point_out_o
);
	logic [16:0] noise_reg = 17'h0AAAA;

	// Leads float between reads; a changing pattern exposes late sampling
	always_ff @(posedge ref_clk_i) begin
		noise_reg <= ~noise_reg;
	end

	always_comb begin
		aux_point_out_o = noise_reg;
		if (ring_word_read_i) begin
			aux_point_out_o = off_hook_i & {17{|ring_bits_i}};
			if (|ring_bits_i[15:8]) begin
				aux_point_out_o[4] = 1'b0;
			end
		end
	end
endmodule

// >>> testbench/asps_scanner_sva.sv
/*
 * Port level assertions for the scanner.
 * Assumes it is bound to every asps_scanner instance.
 */
`timescale 1ns/100ps

module asps_scanner_sva (
	input wire logic        ref_clk_i,
	input wire logic        reset_n_i,
	input wire logic        report_done_reset_i,
	input wire logic        ring_word_read_o,
	input wire logic        ring_word_clear_o,
	input wire logic        sixteenth_strobe_o,
	input wire logic [15:0] ring_bits_o,
	input wire logic        counter_select_hi_o,
	input wire logic        counter_select_mid_o,
	input wire logic        state_bus_true_o,
	input wire logic        state_bus_false_o,
	input wire logic        send_report_strobe_o,
	input wire logic        send_request_o,
	input wire logic [10:0] scan_count_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	property p_row;
		ring_word_read_o |-> ring_bits_o == (16'h0001 << scan_count_o[3:0]);
	endproperty
	a_row: assert property (p_row) else $error("ring bit off row");
	property p_idle;
		!ring_word_read_o |-> ring_bits_o == 16'h0000;
	endproperty
	a_idle: assert property (p_idle) else $error("ring bits outside read");
	property p_init;
		(ring_word_read_o && scan_count_o[3:0] == 4'h0) |->
			sixteenth_strobe_o && ring_word_clear_o;
	endproperty
	a_init: assert property (p_init) else $error("ring not initialised");
	property p_sel;
		counter_select_hi_o == scan_count_o[10] && counter_select_mid_o == scan_count_o[8];
	endproperty
	a_sel: assert property (p_sel) else $error("select lines wrong");
	property p_slots;
		ring_word_read_o |=> !ring_word_read_o [*3];
	endproperty
	a_slots: assert property (p_slots) else $error("slot order broken");
	property p_req;
		send_report_strobe_o |-> send_request_o ##1 !send_report_strobe_o;
	endproperty
	a_req: assert property (p_req) else $error("strobe without request");
	property p_hold;
		send_request_o && !report_done_reset_i |=> send_request_o && $stable(scan_count_o);
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
	property p_block;
		send_request_o |-> !ring_word_read_o;
	endproperty
	a_block: assert property (p_block) else $error("scan while request");
	property p_clear;
		report_done_reset_i && !send_report_strobe_o |=> !send_request_o;
	endproperty
	a_clear: assert property (p_clear) else $error("done not taken");
	property p_walk;
		$changed(scan_count_o) |-> !$past(send_request_o) &&
			((scan_count_o == $past(scan_count_o) + 11'h001 && scan_count_o != 11'h148)
			|| ($past(scan_count_o) == 11'h147 && scan_count_o == 11'h400)
			|| ($past(scan_count_o) == 11'h47F && scan_count_o == 11'h500)
			|| ($past(scan_count_o) == 11'h53F && scan_count_o == 11'h100));
	endproperty
	a_walk: assert property (p_walk) else $error("bad count step");
	property p_rail;
		!(state_bus_true_o && state_bus_false_o);
	endproperty
	a_rail: assert property (p_rail) else $error("both rails high");

	c_strobe: cover property (send_report_strobe_o);
	c_init: cover property (sixteenth_strobe_o);
	c_false: cover property (state_bus_false_o);
	c_done: cover property (report_done_reset_i && send_request_o);
endmodule

bind asps_scanner asps_scanner_sva asps_scanner_sva_i (.ref_clk_i, .reset_n_i,
	.report_done_reset_i, .ring_word_read_o, .ring_word_clear_o, .sixteenth_strobe_o,
	.ring_bits_o, .counter_select_hi_o, .counter_select_mid_o, .state_bus_true_o,
	.state_bus_false_o, .send_report_strobe_o, .send_request_o, .scan_count_o);

// >>> testbench/testbench.sv
/*
 * Self-checking testbench: scan sweeps with reports, register access.
 * Assumes the point model and the bound checker are compiled first.
 */
`timescale 1ns/100ps

module testbench;
	import asps_pkg::*;

	logic        ref_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        report_done_reset_i = 1'b0;
	logic [3:0]  addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic [16:0] off_hook = 17'h0;
	logic [31:0] rdata_o, report_word_o;
	logic [16:0] aux_point_out_i;
	logic [15:0] ring_bits_o;
	logic [10:0] scan_count_o;
	logic        ring_word_read_o, ring_word_clear_o, sixteenth_strobe_o;
	logic        counter_select_hi_o, counter_select_mid_o, report_word_clear_o;
	logic        state_bus_true_o, state_bus_false_o, send_report_strobe_o, send_request_o;
	int          bad_count = 0;
	int          n_checks = 0;
	int          cycles = 0;
	int          wait_k = 0;

	asps_scanner asps_scanner_i (.ref_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .aux_point_out_i, .report_done_reset_i, .ring_word_read_o,
		.ring_word_clear_o, .sixteenth_strobe_o, .ring_bits_o, .counter_select_hi_o,
		.counter_select_mid_o, .report_word_clear_o, .report_word_o, .state_bus_true_o,
		.state_bus_false_o, .send_report_strobe_o, .send_request_o, .scan_count_o);

	asps_point_model asps_point_model_i (.ref_clk_i, .ring_word_read_i(ring_word_read_o),
		.ring_bits_i(ring_bits_o), .off_hook_i(off_hook), .aux_point_out_o(aux_point_out_i));

	initial begin
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	task final_report;
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Three sweeps plus register work stay far below this
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			bad_count++;
			final_report;
		end
	end

	task chk(input logic ok, input string send_request_ff);
		n_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("ERROR %0t %s", $time, send_request_ff);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	// First sweep only seeds the unreset last-look store
	task automatic sweep(input logic ps, input bit judge);
		logic [10:0] c;
		logic [4:0]  col;
		logic        ow;
		int          k;
		c = PT_FIRST;
		@(posedge ref_clk_i);
		off_hook <= {17{ps}};
		#1;
		do begin
			k = 0;
			while (ring_word_read_o !== 1'b1 && k < 40) begin
				tick(1);
				k++;
			end
			chk(scan_count_o === c, "scan count");
			col = c[10] ? (c[8] ? COL_BASE_THIRD + c[5:4] : COL_BASE_SECOND + c[6:4])
				: {1'b0, c[7:4]};
			ow = OW_ALL_DEF[col] | (c[3] & OW_UPPER_DEF[col]);
			tick(3);
			if (judge)
				chk(send_request_o === (ps | ~ow), "request");
			if (send_request_o === 1'b1) begin
				tick(3);
				if (judge) begin
					chk(report_word_o === {3'h0, 1'b1, c, ps, 16'h0000}, "report");
					chk(state_bus_true_o === ps && state_bus_false_o === ~ps, "rails");
				end
				@(posedge ref_clk_i);
				report_done_reset_i <= 1'b1;
				@(posedge ref_clk_i);
				report_done_reset_i <= 1'b0;
			end
			c = (c == 11'h147) ? PT_GAP_TO : (c == 11'h47F) ? PT_JUMP_TO
				: (c == PT_LAST) ? PT_FIRST : c + 11'h001;
		end while (c != PT_FIRST);
	endtask

	task automatic reg_test;
		logic [31:0] d;
		int          k;
		rd(REG_CTRL, d);
		chk(d[CTRL_EN_BIT] === CTRL_EN_RST, "ctrl reset");
		wr(REG_CTRL, 32'h0000_0000);
		tick(4);
		k = 0;
		repeat (12) begin
			if (ring_word_read_o !== 1'b0)
				k++;
			tick(1);
		end
		chk(k == 0, "read while disabled");
		rd(REG_STATUS, d);
		chk(d[ST_SEND_BIT] === 1'b0 && d[ST_HALT_BIT] === 1'b0, "status");
		rd(4'hC, d);
		chk(d === 32'h0000_0000, "unmapped read");
		wr(REG_CTRL, 32'h0000_0001);
		k = 0;
		while (ring_word_read_o !== 1'b1 && k < 20) begin
			tick(1);
			k++;
		end
		chk(k < 20, "scan resumes");
	endtask

	initial begin
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		#1;
		chk(scan_count_o === PT_FIRST && counter_select_mid_o === 1'b1
			&& counter_select_hi_o === 1'b0, "reset state");
		// Point 256 is read right after reset; realign on the wrap
		wait_k = 0;
		while (scan_count_o !== PT_LAST && wait_k < 2000) begin
			tick(1);
			wait_k++;
		end
		sweep(1'b1, 1'b0);
		sweep(1'b0, 1'b1);
		sweep(1'b1, 1'b1);
		reg_test;
		final_report;
	end
endmodule
